//--- hw/radio_regs_pkg.sv
// Constants for the radio status, observe and receive address register bank
package radio_regs_pkg;

   // ****************************************************************
   // Register offsets (five bit register address)
   // ****************************************************************
   localparam logic [4:0] radio_status_off          = 5'h07;
   localparam logic [4:0] transmit_observe_off      = 5'h08;
   localparam logic [4:0] received_power_detect_off = 5'h09;
   localparam logic [4:0] pipe0_receive_address_off = 5'h0A;
   localparam logic [4:0] pipe1_receive_address_off = 5'h0B;
   localparam logic [4:0] pipe2_address_low_off     = 5'h0C;
   localparam logic [4:0] pipe3_address_low_off     = 5'h0D;

   // ****************************************************************
   // Command byte layout: top three bits select the operation
   // ****************************************************************
   localparam int         cmd_op_hi     = 7;
   localparam int         cmd_op_lo     = 5;
   localparam int         cmd_addr_hi   = 4;
   localparam logic [2:0] cmd_op_read   = 3'h0;
   localparam logic [2:0] cmd_op_write  = 3'h1;

   // ****************************************************************
   // Status field positions and reset values
   // ****************************************************************
   localparam int         receive_ready_bit  = 6;
   localparam int         transmit_done_bit  = 5;
   localparam int         retry_limit_bit    = 4;
   localparam logic [2:0] pipe_no_empty      = 3'h7;

   // ****************************************************************
   // Observe counters
   // ****************************************************************
   localparam logic [3:0] counter_max = 4'hF;

   // ****************************************************************
   // Address width codes and address reset values
   // ****************************************************************
   localparam logic [1:0]  width_code_illegal = 2'h0;
   localparam logic [2:0]  width_min_bytes    = 3'h3;
   localparam logic [2:0]  width_code_offset  = 3'h2;
   localparam logic [39:0] pipe0_address_reset = 40'hE7E7E7E7E7;
   localparam logic [39:0] pipe1_address_reset = 40'hC2C2C2C2C2;
   localparam logic [7:0]  pipe2_low_reset     = 8'hC3;
   localparam logic [7:0]  pipe3_low_reset     = 8'hC4;

   // ****************************************************************
   // Serial framing
   // ****************************************************************
   localparam logic [2:0] last_bit_index  = 3'h7;
   localparam logic [2:0] byte_count_max  = 3'h7;

endpackage

//--- hw/radio_status_address_regs.sv
// Serial register bank: status, transmit observe, power detect, pipe 0-3 addresses

// Behaviour
// - Status shifts out while command byte shifts in
// - Receive ready flag sets on payload; write-one clears
// - Transmit done flag; after acknowledge when enabled
// - Retry limit flag blocks traffic until cleared
// - Pipe number field; 111 means FIFO empty
// - Status bit 0 shows transmit FIFO full
// - Lost counter saturates at 15; channel write clears
// - Retransmit counter restarts with each new packet
// - Power detect bit 0, upper bits zero
// - Pipe 0 address, low byte first, width bytes
// - Pipe 1 address, low byte first, width bytes
// - Pipe 2 upper bytes come from pipe 1
// - Pipe 3 upper bytes come from pipe 1
// - Width codes 01/10/11 give 3/4/5 bytes
module radio_status_address_regs (
   input  wire logic        core_clk,               // Core clock, 200 MHz
   input  wire logic        rst_b,                  // Synchronous reset, active low
   input  wire logic        sck,                    // Serial clock pin
   input  wire logic        csn_b,                  // Serial select pin, active low
   input  wire logic        mosi,                   // Serial data in pin
   output logic             miso,                   // Serial data out pin
   output logic             miso_oe_b,              // Low while miso is driven
   input  wire logic        rx_payload_stored,      // Pulse: payload entered receive FIFO
   input  wire logic        packet_sent,            // Pulse: packet left the transmitter
   input  wire logic        ack_received,           // Pulse: acknowledge received
   input  wire logic        auto_ack_enabled,       // Level: automatic acknowledge on
   input  wire logic        retry_limit_hit,        // Pulse: retransmit limit reached
   input  wire logic [2:0]  rx_pipe_number,         // Pipe of next readable payload
   input  wire logic        tx_fifo_full,           // Level: transmit FIFO full
   input  wire logic        lost_packet,            // Pulse: packet lost
   input  wire logic        retransmit,             // Pulse: retransmission started
   input  wire logic        new_packet_start,       // Pulse: new packet transmission starts
   input  wire logic        channel_write,          // Pulse: channel register written
   input  wire logic        power_detect,           // Level: received power detector
   input  wire logic [1:0]  address_width_setting,  // Address width code
   output logic             comm_blocked,           // High while retry limit flag is set
   output logic [39:0]      pipe0_receive_address,  // Pipe 0 address
   output logic [39:0]      pipe1_receive_address,  // Pipe 1 address
   output logic [39:0]      pipe2_address,          // Pipe 2 full address
   output logic [39:0]      pipe3_address           // Pipe 3 full address
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic        sck_s1;
      logic        sck_s2;
      logic        sck_s3;
      logic        csn_s1;
      logic        csn_s2;
      logic        csn_s3;
      logic        mosi_s1;
      logic        mosi_s2;
      logic [2:0]  bit_cnt;
      logic [2:0]  byte_cnt;
      logic [7:0]  cmd;
      logic [7:0]  shift_in;
      logic [7:0]  shift_out;
      logic        miso;
      logic        miso_oe_b;
      logic        receive_ready_flag;
      logic        transmit_done_flag;
      logic        retry_limit_flag;
      logic [3:0]  lost_packet_counter;
      logic [3:0]  retransmission_counter;
      logic [39:0] pipe0;
      logic [39:0] pipe1;
      logic [7:0]  pipe2_low;
      logic [7:0]  pipe3_low;
   } state_t;

   state_t s_q;
   state_t s_d;

   // Number of address bytes the width code allows
   function automatic logic [2:0] width_bytes(input logic [1:0] code);
      // Illegal code treated as the shortest width so no stray bytes land
      if (code == radio_regs_pkg::width_code_illegal) begin
         return radio_regs_pkg::width_min_bytes;
      end
      return {1'b0, code} + radio_regs_pkg::width_code_offset;
   endfunction

   // Status byte as seen on the serial line
   function automatic logic [7:0] status_byte(input state_t s,
                                              input logic [2:0] pipe_no,
                                              input logic full);
      logic [7:0] v;
      v = 8'h00;
      v[radio_regs_pkg::receive_ready_bit] = s.receive_ready_flag;
      v[radio_regs_pkg::transmit_done_bit] = s.transmit_done_flag;
      v[radio_regs_pkg::retry_limit_bit]   = s.retry_limit_flag;
      v[3:1] = pipe_no;
      v[0]   = full;
      return v;
   endfunction

   // ****************************************************************
   // Read data mux
   // ****************************************************************
   logic [2:0] width_n;
   logic [2:0] data_idx;
   logic [4:0] reg_addr;
   logic [7:0] rd_byte;
   logic [7:0] stat_now;

   assign width_n  = width_bytes(address_width_setting);
   assign data_idx = s_q.byte_cnt - 3'h1;
   assign reg_addr = s_q.cmd[radio_regs_pkg::cmd_addr_hi:0];
   assign stat_now = status_byte(s_q, rx_pipe_number, tx_fifo_full);

   // Byte index beyond the address width reads zero
   always_comb begin
      rd_byte = 8'h00;
      if (s_q.cmd[radio_regs_pkg::cmd_op_hi:radio_regs_pkg::cmd_op_lo]
          == radio_regs_pkg::cmd_op_read) begin
         unique case (reg_addr)
            radio_regs_pkg::radio_status_off: begin
               if (data_idx == 3'h0) rd_byte = stat_now;
            end
            radio_regs_pkg::transmit_observe_off: begin
               if (data_idx == 3'h0) rd_byte = {s_q.lost_packet_counter,
                                                s_q.retransmission_counter};
            end
            radio_regs_pkg::received_power_detect_off: begin
               if (data_idx == 3'h0) rd_byte = {7'h00, power_detect};
            end
            radio_regs_pkg::pipe0_receive_address_off: begin
               if (data_idx < width_n) rd_byte = s_q.pipe0[{data_idx, 3'h0} +: 8];
            end
            radio_regs_pkg::pipe1_receive_address_off: begin
               if (data_idx < width_n) rd_byte = s_q.pipe1[{data_idx, 3'h0} +: 8];
            end
            radio_regs_pkg::pipe2_address_low_off: begin
               if (data_idx == 3'h0) rd_byte = s_q.pipe2_low;
            end
            radio_regs_pkg::pipe3_address_low_off: begin
               if (data_idx == 3'h0) rd_byte = s_q.pipe3_low;
            end
            default: rd_byte = 8'h00;
         endcase
      end
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   logic       sck_rise;
   logic       sck_fall;
   logic       cs_start;
   logic       cs_active;
   logic [7:0] byte_in;
   logic [2:0] wr_idx;

   assign sck_rise  = s_q.sck_s2 & ~s_q.sck_s3;
   assign sck_fall  = ~s_q.sck_s2 & s_q.sck_s3;
   assign cs_start  = ~s_q.csn_s2 & s_q.csn_s3;
   assign cs_active = ~s_q.csn_s2;
   assign byte_in   = {s_q.shift_in[6:0], s_q.mosi_s2};
   assign wr_idx    = data_idx;

   always_comb begin
      s_d = s_q;
      // Pin synchronisers; the second stage feeds logic, and the third stage feeds the sck and select edge detectors
      s_d.sck_s1  = sck;
      s_d.sck_s2  = s_q.sck_s1;
      s_d.sck_s3  = s_q.sck_s2;
      s_d.csn_s1  = csn_b;
      s_d.csn_s2  = s_q.csn_s1;
      s_d.csn_s3  = s_q.csn_s2;
      s_d.mosi_s1 = mosi;
      s_d.mosi_s2 = s_q.mosi_s1;

      // Serial frame: sample on rising edge, shift out on falling edge
      if (cs_start) begin
         s_d.bit_cnt   = 3'h0;
         s_d.byte_cnt  = 3'h0;
         s_d.cmd       = 8'h00;
         s_d.shift_out = stat_now;
      end else if (cs_active && sck_rise) begin
         s_d.shift_in = byte_in;
         s_d.bit_cnt  = s_q.bit_cnt + 3'h1;
         if (s_q.bit_cnt == radio_regs_pkg::last_bit_index) begin
            if (s_q.byte_cnt == 3'h0) begin
               s_d.cmd = byte_in;
            end else if (s_q.cmd[radio_regs_pkg::cmd_op_hi:radio_regs_pkg::cmd_op_lo]
                         == radio_regs_pkg::cmd_op_write) begin
               // Writes to read-only fields fall through unhandled
               unique case (reg_addr)
                  radio_regs_pkg::radio_status_off: begin
                     if (wr_idx == 3'h0) begin
                        // Only ones clear; zeros leave the flag
                        if (byte_in[radio_regs_pkg::receive_ready_bit]) begin
                           s_d.receive_ready_flag = 1'b0;
                        end
                        if (byte_in[radio_regs_pkg::transmit_done_bit]) begin
                           s_d.transmit_done_flag = 1'b0;
                        end
                        if (byte_in[radio_regs_pkg::retry_limit_bit]) begin
                           s_d.retry_limit_flag = 1'b0;
                        end
                     end
                  end
                  radio_regs_pkg::pipe0_receive_address_off: begin
                     // Low byte arrives first; surplus bytes dropped
                     if (wr_idx < width_n) s_d.pipe0[{wr_idx, 3'h0} +: 8] = byte_in;
                  end
                  radio_regs_pkg::pipe1_receive_address_off: begin
                     if (wr_idx < width_n) s_d.pipe1[{wr_idx, 3'h0} +: 8] = byte_in;
                  end
                  radio_regs_pkg::pipe2_address_low_off: begin
                     if (wr_idx == 3'h0) s_d.pipe2_low = byte_in;
                  end
                  radio_regs_pkg::pipe3_address_low_off: begin
                     if (wr_idx == 3'h0) s_d.pipe3_low = byte_in;
                  end
                  default: s_d.cmd = s_q.cmd;
               endcase
            end
            // Byte count saturates so long frames cannot wrap onto the command
            if (s_q.byte_cnt != radio_regs_pkg::byte_count_max) begin
               s_d.byte_cnt = s_q.byte_cnt + 3'h1;
            end
         end
      end else if (cs_active && sck_fall) begin
         if (s_q.bit_cnt == 3'h0) begin
            s_d.shift_out = rd_byte;
         end else begin
            s_d.shift_out = {s_q.shift_out[6:0], 1'b0};
         end
      end
      s_d.miso      = s_d.shift_out[7];
      s_d.miso_oe_b = s_q.csn_s2;

      // Hardware events set after clears, so a same-cycle set wins
      if (rx_payload_stored) begin
         s_d.receive_ready_flag = 1'b1;
      end
      if (auto_ack_enabled ? ack_received : packet_sent) begin
         s_d.transmit_done_flag = 1'b1;
      end
      if (retry_limit_hit) begin
         s_d.retry_limit_flag = 1'b1;
      end

      // Lost counter: channel write takes priority over a count
      if (channel_write) begin
         s_d.lost_packet_counter = 4'h0;
      end else if (lost_packet &&
                   s_q.lost_packet_counter != radio_regs_pkg::counter_max) begin
         s_d.lost_packet_counter = s_q.lost_packet_counter + 4'h1;
      end

      // Retransmit counter restarts with each new packet
      if (new_packet_start) begin
         s_d.retransmission_counter = 4'h0;
      end else if (retransmit &&
                   s_q.retransmission_counter != radio_regs_pkg::counter_max) begin
         s_d.retransmission_counter = s_q.retransmission_counter + 4'h1;
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   // Select synchronisers reset high so release is not taken as a frame start
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         s_q           <= '0;
         s_q.csn_s1    <= 1'b1;
         s_q.csn_s2    <= 1'b1;
         s_q.csn_s3    <= 1'b1;
         s_q.miso_oe_b <= 1'b1;
         s_q.pipe0     <= radio_regs_pkg::pipe0_address_reset;
         s_q.pipe1     <= radio_regs_pkg::pipe1_address_reset;
         s_q.pipe2_low <= radio_regs_pkg::pipe2_low_reset;
         s_q.pipe3_low <= radio_regs_pkg::pipe3_low_reset;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // Outputs, all straight from flip-flops
   // ****************************************************************
   assign miso                  = s_q.miso;
   assign miso_oe_b             = s_q.miso_oe_b;
   assign comm_blocked          = s_q.retry_limit_flag;
   assign pipe0_receive_address = s_q.pipe0;
   assign pipe1_receive_address = s_q.pipe1;
   assign pipe2_address         = {s_q.pipe1[39:8], s_q.pipe2_low};
   assign pipe3_address         = {s_q.pipe1[39:8], s_q.pipe3_low};

endmodule

//--- testbench/radio_host_model.sv
// Host model: serial master issuing register command frames, mode 0
module radio_host_model (
   input  wire logic core_clk, // Core clock
   output logic      sck,      // Serial clock, idle low
   output logic      csn_b,    // Select, active low
   output logic      mosi,     // Data towards device
   input  wire logic miso      // Data from device
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int half_clks = 6; // Margin over the four clock minimum per level
   initial begin
      sck = 1'b0;
      csn_b = 1'b1;
      mosi = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // Most significant bit first; sample late in the high phase
   task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         mosi = tx[i];
         tick(half_clks);
         sck = 1'b1;
         tick(half_clks);
         rx[i] = miso;
         sck = 1'b0;
      end
   endtask
   // Command byte, then data bytes with the lowest byte first
   task automatic frame(input logic [7:0] cmd, input int nbytes, input logic [39:0] wdata,
                        output logic [7:0] status, output logic [39:0] rdata);
      logic [7:0] rx;
      rdata = 40'h0;
      csn_b = 1'b0;
      tick(half_clks);
      shift_byte(cmd, status);
      for (int k = 0; k < nbytes; k++) begin
         shift_byte(wdata[8*k +: 8], rx);
         rdata[8*k +: 8] = rx;
      end
      tick(half_clks);
      csn_b = 1'b1;
      mosi = ~mosi; // Released line must not look like a stale bit
      tick(2 * half_clks);
   endtask
endmodule

//--- testbench/radio_regs_asserts.sv
// Port level checks of the radio status and address register bank
module radio_status_address_regs_asserts (
   input wire logic        core_clk,              // Core clock
   input wire logic        rst_b,                 // Synchronous reset, active low
   input wire logic        csn_b,                 // Serial select, active low
   input wire logic        miso_oe_b,             // Low while miso is driven
   input wire logic        retry_limit_hit,       // Retry limit event
   input wire logic        comm_blocked,          // Traffic blocked
   input wire logic [39:0] pipe0_receive_address, // Pipe 0 address
   input wire logic [39:0] pipe1_receive_address, // Pipe 1 address
   input wire logic [39:0] pipe2_address,         // Pipe 2 address
   input wire logic [39:0] pipe3_address          // Pipe 3 address
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // ****************************************************************
   // Select settles after the synchroniser, so six cycles are allowed
   // ****************************************************************
   sequence s_idle;
      csn_b [*6];
   endsequence
   sequence s_selected;
      !csn_b [*6];
   endsequence
   AST_OE_IDLE: assert property (s_idle |-> miso_oe_b)
      else $error("Data out driven while deselected");
   AST_OE_DRIVE: assert property (s_selected |-> !miso_oe_b)
      else $error("Data out not driven while selected");
   AST_BLOCK_SET: assert property (retry_limit_hit |=> comm_blocked)
      else $error("Retry limit event did not block traffic");
   AST_BLOCK_HOLD: assert property (s_idle ##0 comm_blocked |=> comm_blocked)
      else $error("Block released without a clearing write");
   AST_ADDR_QUIET: assert property (s_idle |=> $stable(pipe0_receive_address)
      && $stable(pipe1_receive_address))
      else $error("Address changed with no frame");
   AST_PIPE2_UPPER: assert property ($stable(pipe1_receive_address)
      |-> pipe2_address[39:8] == pipe1_receive_address[39:8])
      else $error("Pipe 2 upper bytes differ from pipe 1");
   AST_PIPE3_UPPER: assert property ($stable(pipe1_receive_address)
      |-> pipe3_address[39:8] == pipe1_receive_address[39:8])
      else $error("Pipe 3 upper bytes differ from pipe 1");
   AST_RESET_VALS: assert property (disable iff (1'b0) !rst_b |=>
      pipe0_receive_address == 40'hE7E7E7E7E7 && pipe1_receive_address == 40'hC2C2C2C2C2
      && !comm_blocked && miso_oe_b)
      else $error("Reset values wrong");
endmodule

bind radio_status_address_regs radio_status_address_regs_asserts radio_status_address_regs_asserts_inst (
   .core_clk(core_clk), .rst_b(rst_b), .csn_b(csn_b), .miso_oe_b(miso_oe_b),
   .retry_limit_hit(retry_limit_hit), .comm_blocked(comm_blocked),
   .pipe0_receive_address(pipe0_receive_address), .pipe1_receive_address(pipe1_receive_address),
   .pipe2_address(pipe2_address), .pipe3_address(pipe3_address));

//--- testbench/radio_status_address_regs_tb.sv
// Self-checking bench for the radio status and address register bank
module radio_status_address_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk, rst_b, sck, csn_b, mosi, miso, miso_oe_b, miso_line;
   logic        auto_ack, pwr, blocked, full;
   logic [7:0]  ev, st;
   logic [2:0]  pipe_no;
   logic [1:0]  width;
   logic [39:0] p0, p1, p2, p3, rd;
   int          err_total, checked, cyc;
   // Undriven data out toggles so the host never sees a stale bit
   assign miso_line = miso_oe_b ? ~sck : miso;
   radio_status_address_regs radio_status_address_regs_inst (
      .core_clk(core_clk), .rst_b(rst_b), .sck(sck), .csn_b(csn_b), .mosi(mosi), .miso(miso),
      .miso_oe_b(miso_oe_b), .rx_payload_stored(ev[0]), .packet_sent(ev[1]),
      .ack_received(ev[2]), .auto_ack_enabled(auto_ack), .retry_limit_hit(ev[3]),
      .rx_pipe_number(pipe_no), .tx_fifo_full(full), .lost_packet(ev[4]), .retransmit(ev[5]),
      .new_packet_start(ev[6]), .channel_write(ev[7]), .power_detect(pwr),
      .address_width_setting(width), .comm_blocked(blocked), .pipe0_receive_address(p0),
      .pipe1_receive_address(p1), .pipe2_address(p2), .pipe3_address(p3));
   radio_host_model radio_host_model_inst (
      .core_clk(core_clk), .sck(sck), .csn_b(csn_b), .mosi(mosi), .miso(miso_line));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic xfer(input logic [7:0] cmd, input int n, input logic [39:0] wd);
      radio_host_model_inst.frame(cmd, n, wd, st, rd);
   endtask
   // Hold the chosen events high for n cycles; each high cycle counts
   // Returns just after an edge so a following pulse cannot race the sampling edge
   task automatic pulse(input logic [7:0] mask, input int n);
      ev = mask;
      repeat (n) @(posedge core_clk);
      #1 ev = 8'h00;
      repeat (2) @(posedge core_clk);
      #1;
   endtask
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Ceiling well above the roughly 8000 cycles the frames need
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         end_of_test();
      end
   end
   initial begin
      {rst_b, ev, auto_ack, pwr, full, err_total, checked, cyc} = '0;
      auto_ack = 1'b1;
      pipe_no = 3'h7;
      width = 2'h3;
      repeat (16) @(posedge core_clk);
      #1 rst_b = 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      xfer(8'h0A, 5, 40'h0);
      check("status", 40'(st), 40'h0E);
      check("pipe0", rd, 40'hE7E7E7E7E7);
      xfer(8'h0B, 5, 40'h0);
      check("pipe1", rd, 40'hC2C2C2C2C2);
      xfer(8'h0C, 1, 40'h0);
      check("pipe2 low", rd, 40'hC3);
      xfer(8'h0D, 1, 40'h0);
      check("pipe3 low", rd, 40'hC4);
      check("pipe3 port", p3, 40'hC2C2C2C2C4);
      $display("Test reset values done");
      width = 2'h1;
      xfer(8'h2B, 5, 40'h5544332211);
      check("pipe1 short", p1, 40'hC2C2332211);
      xfer(8'h2C, 1, 40'h99);
      check("pipe2 port", p2, 40'hC2C2332299);
      check("pipe3 upper", p3, 40'hC2C23322C4);
      width = 2'h3;
      xfer(8'h2A, 5, 40'h0102030405);
      xfer(8'h0A, 5, 40'h0);
      check("pipe0 back", rd, 40'h0102030405);
      xfer(8'hCA, 5, 40'h1122334455);
      check("bad cmd data", rd, 40'h0);
      check("bad cmd pipe0", p0, 40'h0102030405);
      // Four byte width keeps the top byte; code 00 acts as three bytes
      width = 2'h2;
      xfer(8'h2A, 5, 40'hAABBCCDDEE);
      check("pipe0 four", p0, 40'h01BBCCDDEE);
      width = 2'h0;
      xfer(8'h0A, 5, 40'h0);
      check("pipe0 code 00", rd, 40'h0000CCDDEE);
      width = 2'h3;
      $display("Test addresses done");
      full = 1'b1;
      pipe_no = 3'h2;
      pulse(8'h02, 1);
      xfer(8'h07, 0, 40'h0);
      check("status no ack", 40'(st), 40'h05);
      pulse(8'h0D, 1);
      xfer(8'h27, 1, 40'h00);
      xfer(8'h07, 0, 40'h0);
      check("status flags", 40'(st), 40'h75);
      check("blocked", 40'(blocked), 40'h1);
      xfer(8'h27, 1, 40'h40);
      xfer(8'h07, 0, 40'h0);
      check("status rx clear", 40'(st), 40'h35);
      xfer(8'h27, 1, 40'h30);
      check("unblocked", 40'(blocked), 40'h0);
      auto_ack = 1'b0;
      pulse(8'h02, 1);
      xfer(8'h07, 0, 40'h0);
      check("status sent", 40'(st), 40'h25);
      $display("Test status done");
      pulse(8'h10, 17);
      pulse(8'h20, 3);
      xfer(8'h08, 1, 40'h0);
      check("observe sat", rd, 40'hF3);
      pulse(8'h20, 1);
      pulse(8'h40, 1);
      xfer(8'h28, 1, 40'h55);
      xfer(8'h08, 1, 40'h0);
      check("observe new", rd, 40'hF0);
      pulse(8'h90, 1);
      xfer(8'h08, 1, 40'h0);
      check("observe chan", rd, 40'h00);
      pwr = 1'b1;
      xfer(8'h29, 1, 40'hFE);
      xfer(8'h09, 1, 40'h0);
      check("power detect", rd, 40'h01);
      $display("Test counters done");
      end_of_test();
   end
endmodule
